// File: dls_drive_model.sv
// Behavioural drive on the far side of the exchange link.
// Assumes dls_pkg is compiled first; answer delay follows the low four bits of the wait word.
`timescale 1ns/100ps
module dls_drive_model (
   input  wire logic                         clk,
   input  wire logic                         nrst,
   input  wire dls_pkg::dls_xchg_req_t [1:0] req,
   input  wire logic                         fail,
   output      dls_pkg::dls_xchg_rsp_t [1:0] rsp
);
   logic [4:0] cnt_r [2];
   always_ff @(posedge clk or negedge nrst) begin
      for (int c = 0; c < 2; c++) begin
         if (!nrst) begin
            cnt_r[c] <= '0;
            rsp[c]   <= '0;
         end else begin
            if (req[c].start) cnt_r[c] <= {1'b0, req[c].wait_time[3:0]} + 5'h2;
            else if (cnt_r[c] != 5'h0) cnt_r[c] <= cnt_r[c] - 5'h1;
            rsp[c].done  <= (cnt_r[c] == 5'h1);
            rsp[c].fault <= (cnt_r[c] == 5'h1) && fail;
            rsp[c].code  <= (cnt_r[c] == 5'h1) ? 16'h0042 : ~rsp[c].code;
            rsp[c].param <= (cnt_r[c] == 5'h1) ? 16'h0003 : ~rsp[c].param;
         end
      end
   end
endmodule

// File: dls_pkg.sv
// Constants, enumerations and carrier structs of the drive link status bank.
// Assumes a 100 MHz system clock and one status bank per two serial channels.
package dls_pkg;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned GAP_TIME_US  = 15000;
   localparam int unsigned GAP_CYC      = GAP_TIME_US * CLK_MHZ;
   localparam int unsigned NUM_CH       = 2;
   localparam int unsigned WORD_W       = 16;

   // -------------------------------------------------------------------------
   // Register map (byte addresses, channel 2 at CH_STRIDE above channel 1)
   // -------------------------------------------------------------------------
   localparam logic [7:0] CH_STRIDE       = 8'h20;
   localparam logic [4:0] OFF_FLAGS       = 5'h00;
   localparam logic [4:0] OFF_WAIT        = 5'h04;
   localparam logic [4:0] OFF_ACT_STEP    = 5'h08;
   localparam logic [4:0] OFF_DRV_CODE    = 5'h0c;
   localparam logic [4:0] OFF_ERR_STEP    = 5'h10;
   localparam logic [4:0] OFF_BATCH_PARAM = 5'h14;
   localparam logic [4:0] OFF_SER_CODE    = 5'h18;
   localparam logic [7:0] OFF_SHARED      = 8'h40;
   localparam logic [7:0] OFF_CTRL        = 8'h44;

   // Flag register bit positions
   localparam int unsigned FB_SER_FAULT   = 0;
   localparam int unsigned FB_BUSY        = 1;
   localparam int unsigned FB_DRV_FAULT   = 2;
   localparam int unsigned FB_DRV_LATCH   = 3;
   localparam int unsigned FB_BATCH_FAULT = 4;
   // Shared and control bit positions
   localparam int unsigned SB_INSTR_DONE  = 0;
   localparam int unsigned CB_LEGACY_MAP  = 0;

   // -------------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------------
   localparam logic [15:0] RST_WAIT       = 16'h0000;
   localparam logic [15:0] RST_WORD       = 16'h0000;

   localparam logic [1:0] RESP_OKAY       = 2'b00;
   localparam logic [1:0] RESP_SLVERR     = 2'b10;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_MONITOR, CMD_CONTROL, CMD_READ_PARAM, CMD_WRITE_PARAM, CMD_BATCH_WRITE
   } dls_cmd_t;

   typedef enum logic [1:0] {CH_IDLE, CH_BUSY, CH_GAP} dls_ch_state_t;

   typedef struct packed {
      logic        cond;
      dls_cmd_t    cmd;
      logic [15:0] step;
   } dls_drv_req_t;

   typedef struct packed {
      logic        done;
      logic        fault;
      logic [15:0] code;
      logic [15:0] param;
   } dls_xchg_rsp_t;

   typedef struct packed {
      logic        fault;
      logic [15:0] code;
   } dls_line_evt_t;

   typedef struct packed {
      logic        start;
      dls_cmd_t    cmd;
      logic [15:0] wait_time;
   } dls_xchg_req_t;

endpackage

// File: dls_status_bank.sv
// Status and setting bank of a two channel drive link, with AXI4-Lite access.
// Assumes the exchange engine answers each start with one done pulse, and a
// scan tick pulse marks each program scan boundary.
//
// Summary of operation
// - Shared completion flag rises at the scan tick after an instruction ends, holds exactly one scan.
// - Completion flag also rises when the instruction ends with drive fault.
// - Serial fault flag sets on a line error on that channel, and on a drive fault except in legacy map.
// - Busy flag is high exactly while an exchange runs on the channel.
// - Drive fault flag sets when an exchange with the drive fails.
// - Drive fault latch copy stays set after an error.
// - Batch write fault flag sets when a batch write fails.
// - Serial error code word keeps the latest serial error, read only.
// - Response wait time word is writable, read back and sent with each exchange.
// - Active step word holds the executing step while an exchange runs.
// - Drive error code word stores the code of a failed exchange.
// - Error step word latches the step of the failing instruction.
// - Batch error parameter word stores the failing parameter number.
// - STOP to RUN change clears fault flags, latch and error words.
// - In legacy map the serial fault flag ignores pure drive faults.
// - Five exchange types: monitor, control, read, write, batch write.
// - After the port frees, wait before starting the next pending exchange.
// - Start on drive condition rising edge, or again after the gap while it stays high; finish even if it falls.
`timescale 1ns/100ps

module dls_status_bank #(
   parameter int unsigned GAP_CYCLES = dls_pkg::GAP_CYC,
   parameter int unsigned ADDR_W     = 8
) (
   input  wire logic                  CLK_SYS,
   input  wire logic                  NRST,
   input  wire logic [ADDR_W-1:0]     S_AWADDR,
   input  wire logic                  S_AWVALID,
   output      logic                  S_AWREADY,
   input  wire logic [31:0]           S_WDATA,
   input  wire logic [3:0]            S_WSTRB,
   input  wire logic                  S_WVALID,
   output      logic                  S_WREADY,
   output      logic [1:0]            S_BRESP,
   output      logic                  S_BVALID,
   input  wire logic                  S_BREADY,
   input  wire logic [ADDR_W-1:0]     S_ARADDR,
   input  wire logic                  S_ARVALID,
   output      logic                  S_ARREADY,
   output      logic [31:0]           S_RDATA,
   output      logic [1:0]            S_RRESP,
   output      logic                  S_RVALID,
   input  wire logic                  S_RREADY,
   input  wire logic                  SCAN_TICK,
   input  wire logic                  RUN_MODE,
   input  wire dls_pkg::dls_drv_req_t [1:0] DRV_REQ,
   input  wire dls_pkg::dls_xchg_rsp_t [1:0] XCHG_RSP,
   input  wire dls_pkg::dls_line_evt_t [1:0] LINE_EVT,
   output      dls_pkg::dls_xchg_req_t [1:0] XCHG_REQ,
   output      logic [1:0]            DRIVE_BUSY,
   output      logic                  INSTR_DONE
);

   // ------------------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------------------
   if (GAP_CYCLES < 1 || GAP_CYCLES >= (1 << 24)) begin : g_bad_gap
      $error("GAP_CYCLES out of range");
   end
   if (ADDR_W < 7) begin : g_bad_addr
      $error("ADDR_W too small for the map");
   end

   default clocking cb_sys @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);

   // ------------------------------------------------------------------------
   // Shared state
   // ------------------------------------------------------------------------
   logic        run_q_r;
   logic        legacy_r;
   logic        done_pend_r;
   logic        done_flag_r;
   logic [1:0]  ch_done;
   logic [1:0]  ch_start;
   wire         run_rise = RUN_MODE & ~run_q_r;
   wire         any_done = |ch_done;

   // Per channel storage
   dls_pkg::dls_ch_state_t state_r [2];
   logic [23:0] gap_cnt_r    [2];
   logic        pend_r       [2];
   logic        cond_q_r     [2];
   dls_pkg::dls_cmd_t cmd_r  [2];
   logic [15:0] wait_r       [2];
   logic [15:0] act_step_r   [2];
   logic [15:0] drv_code_r   [2];
   logic [15:0] err_step_r   [2];
   logic [15:0] batch_par_r  [2];
   logic [15:0] ser_code_r   [2];
   logic        ser_fault_r  [2];
   logic        drv_fault_r  [2];
   logic        drv_latch_r  [2];
   logic        batch_flt_r  [2];
   logic [15:0] ch_rd        [2];

   // ------------------------------------------------------------------------
   // AXI4-Lite write path
   // ------------------------------------------------------------------------
   logic              aw_have_r;
   logic              w_have_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0]       w_data_r;
   logic [3:0]        w_strb_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;

   assign S_AWREADY = ~aw_have_r & ~bvalid_r;
   assign S_WREADY  = ~w_have_r & ~bvalid_r;
   assign S_BVALID  = bvalid_r;
   assign S_BRESP   = bresp_r;

   wire         wr_fire  = aw_have_r & w_have_r & ~bvalid_r;
   wire [7:0]   wr_addr  = 8'(aw_addr_r);
   wire         wr_ch    = wr_addr[5];
   wire [4:0]   wr_off   = wr_addr[4:0];
   wire         wr_in_ch = wr_addr < dls_pkg::OFF_SHARED;
   wire         wr_wait  = wr_fire & wr_in_ch & (wr_off == dls_pkg::OFF_WAIT);
   wire         wr_ctrl  = wr_fire & (wr_addr == dls_pkg::OFF_CTRL);
   wire         wr_ro    = wr_in_ch & (wr_off <= dls_pkg::OFF_SER_CODE)
                           & (wr_off[1:0] == 2'b00);
   wire         wr_known = wr_ro | (wr_addr == dls_pkg::OFF_SHARED)
                           | (wr_addr == dls_pkg::OFF_CTRL);
   wire [15:0]  wr_merge [2];

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         aw_addr_r <= '0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         if (S_AWVALID && S_AWREADY) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= S_AWADDR;
         end else if (wr_fire) begin
            aw_have_r <= 1'b0;
         end
         if (S_WVALID && S_WREADY) begin
            w_have_r <= 1'b1;
            w_data_r <= S_WDATA;
            w_strb_r <= S_WSTRB;
         end else if (wr_fire) begin
            w_have_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         bvalid_r <= 1'b0;
         bresp_r  <= dls_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_known ? dls_pkg::RESP_OKAY : dls_pkg::RESP_SLVERR;
      end else if (S_BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         legacy_r <= 1'b0;
      end else if (wr_ctrl && w_strb_r[0]) begin
         legacy_r <= w_data_r[dls_pkg::CB_LEGACY_MAP];
      end
   end

   // ------------------------------------------------------------------------
   // AXI4-Lite read path
   // ------------------------------------------------------------------------
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;

   assign S_ARREADY = ~rvalid_r;
   assign S_RVALID  = rvalid_r;
   assign S_RDATA   = rdata_r;
   assign S_RRESP   = rresp_r;

   wire [7:0]  rd_addr  = 8'(S_ARADDR);
   wire        rd_in_ch = rd_addr < dls_pkg::OFF_SHARED;
   wire        rd_ok_ch = rd_in_ch & (rd_addr[4:0] <= dls_pkg::OFF_SER_CODE)
                          & (rd_addr[1:0] == 2'b00);
   wire        rd_shr   = rd_addr == dls_pkg::OFF_SHARED;
   wire        rd_ctl   = rd_addr == dls_pkg::OFF_CTRL;
   wire [31:0] rd_word  = rd_ok_ch ? {16'h0000, ch_rd[rd_addr[5]]}
                        : rd_shr   ? {31'h0, done_flag_r}
                        : rd_ctl   ? {31'h0, legacy_r}
                        : 32'h0000_0000;

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= dls_pkg::RESP_OKAY;
      end else if (S_ARVALID && S_ARREADY) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_word;
         rresp_r  <= (rd_ok_ch | rd_shr | rd_ctl) ? dls_pkg::RESP_OKAY
                                                  : dls_pkg::RESP_SLVERR;
      end else if (S_RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // Shared completion flag
   // ------------------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         run_q_r     <= 1'b0;
         done_pend_r <= 1'b0;
         done_flag_r <= 1'b0;
      end else begin
         run_q_r     <= RUN_MODE;
         done_pend_r <= any_done | (done_pend_r & ~SCAN_TICK);
         if (SCAN_TICK)
            done_flag_r <= done_pend_r;
      end
   end

   assign INSTR_DONE = done_flag_r;

   // ------------------------------------------------------------------------
   // Channels
   // ------------------------------------------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_ch
      wire rise    = DRV_REQ[c].cond & ~cond_q_r[c];
      wire busy    = state_r[c] == dls_pkg::CH_BUSY;
      wire xdone   = busy & XCHG_RSP[c].done;
      wire xfault  = xdone & XCHG_RSP[c].fault;
      wire gap_end = (state_r[c] == dls_pkg::CH_GAP) && (gap_cnt_r[c] == 24'd0);
      wire go      = (state_r[c] == dls_pkg::CH_IDLE) & pend_r[c] & DRV_REQ[c].cond;

      assign ch_done[c]  = xdone;
      assign ch_start[c] = go;
      assign DRIVE_BUSY[c] = busy;
      assign XCHG_REQ[c].start     = go;
      assign XCHG_REQ[c].cmd       = cmd_r[c];
      assign XCHG_REQ[c].wait_time = wait_r[c];
      assign wr_merge[c] = {w_strb_r[1] ? w_data_r[15:8] : wait_r[c][15:8],
                            w_strb_r[0] ? w_data_r[7:0]  : wait_r[c][7:0]};
      assign ch_rd[c] =
           (rd_addr[4:0] == dls_pkg::OFF_FLAGS) ?
              {11'h000, batch_flt_r[c], drv_latch_r[c], drv_fault_r[c], busy,
               ser_fault_r[c]}
         : (rd_addr[4:0] == dls_pkg::OFF_WAIT)        ? wait_r[c]
         : (rd_addr[4:0] == dls_pkg::OFF_ACT_STEP)    ? act_step_r[c]
         : (rd_addr[4:0] == dls_pkg::OFF_DRV_CODE)    ? drv_code_r[c]
         : (rd_addr[4:0] == dls_pkg::OFF_ERR_STEP)    ? err_step_r[c]
         : (rd_addr[4:0] == dls_pkg::OFF_BATCH_PARAM) ? batch_par_r[c]
         : ser_code_r[c];

      // Exchange sequencing
      always_ff @(posedge CLK_SYS or negedge NRST) begin
         if (!NRST) begin
            state_r[c]  <= dls_pkg::CH_IDLE;
            gap_cnt_r[c] <= 24'd0;
            pend_r[c]   <= 1'b0;
            cond_q_r[c] <= 1'b0;
            cmd_r[c]    <= dls_pkg::CMD_MONITOR;
            act_step_r[c] <= dls_pkg::RST_WORD;
         end else begin
            cond_q_r[c] <= DRV_REQ[c].cond;
            case (state_r[c])
               dls_pkg::CH_IDLE: begin
                  if (go) begin
                     state_r[c]    <= dls_pkg::CH_BUSY;
                     pend_r[c]     <= 1'b0;
                     cmd_r[c]      <= DRV_REQ[c].cmd;
                     act_step_r[c] <= DRV_REQ[c].step;
                  end else if (rise) begin
                     pend_r[c] <= 1'b1;
                  end else if (!DRV_REQ[c].cond) begin
                     pend_r[c] <= 1'b0;
                  end
               end
               dls_pkg::CH_BUSY: begin
                  if (rise)
                     pend_r[c] <= 1'b1;
                  if (xdone) begin
                     state_r[c]   <= dls_pkg::CH_GAP;
                     gap_cnt_r[c] <= 24'(GAP_CYCLES - 1);
                  end
               end
               default: begin
                  if (gap_end) begin
                     state_r[c] <= dls_pkg::CH_IDLE;
                     pend_r[c]  <= pend_r[c] | rise | DRV_REQ[c].cond;
                  end else begin
                     gap_cnt_r[c] <= gap_cnt_r[c] - 24'd1;
                     if (rise)
                        pend_r[c] <= 1'b1;
                  end
               end
            endcase
         end
      end

      // Response wait time
      always_ff @(posedge CLK_SYS or negedge NRST) begin
         if (!NRST)
            wait_r[c] <= dls_pkg::RST_WAIT;
         else if (wr_wait && wr_ch == 1'(c))
            wait_r[c] <= wr_merge[c];
      end

      // Fault flags: clear first so a same-cycle event wins
      always_ff @(posedge CLK_SYS or negedge NRST) begin
         if (!NRST) begin
            ser_fault_r[c] <= 1'b0;
            drv_fault_r[c] <= 1'b0;
            drv_latch_r[c] <= 1'b0;
            batch_flt_r[c] <= 1'b0;
         end else begin
            if (run_rise) begin
               ser_fault_r[c] <= 1'b0;
               drv_fault_r[c] <= 1'b0;
               drv_latch_r[c] <= 1'b0;
               batch_flt_r[c] <= 1'b0;
            end
            if (xdone)
               drv_fault_r[c] <= XCHG_RSP[c].fault;
            if (xfault) begin
               drv_latch_r[c] <= 1'b1;
               if (!legacy_r)
                  ser_fault_r[c] <= 1'b1;
               if (cmd_r[c] == dls_pkg::CMD_BATCH_WRITE)
                  batch_flt_r[c] <= 1'b1;
            end
            if (LINE_EVT[c].fault)
               ser_fault_r[c] <= 1'b1;
         end
      end

      // Error words
      always_ff @(posedge CLK_SYS or negedge NRST) begin
         if (!NRST) begin
            drv_code_r[c]  <= dls_pkg::RST_WORD;
            err_step_r[c]  <= dls_pkg::RST_WORD;
            batch_par_r[c] <= dls_pkg::RST_WORD;
            ser_code_r[c]  <= dls_pkg::RST_WORD;
         end else begin
            if (run_rise) begin
               drv_code_r[c]  <= dls_pkg::RST_WORD;
               err_step_r[c]  <= dls_pkg::RST_WORD;
               batch_par_r[c] <= dls_pkg::RST_WORD;
               ser_code_r[c]  <= dls_pkg::RST_WORD;
            end
            if (xfault) begin
               drv_code_r[c] <= XCHG_RSP[c].code;
               err_step_r[c] <= act_step_r[c];
               if (!legacy_r)
                  ser_code_r[c] <= XCHG_RSP[c].code;
               if (cmd_r[c] == dls_pkg::CMD_BATCH_WRITE)
                  batch_par_r[c] <= XCHG_RSP[c].param;
            end
            if (LINE_EVT[c].fault)
               ser_code_r[c] <= LINE_EVT[c].code;
         end
      end

      // ---------------------------------------------------------------------
      // Checks
      // ---------------------------------------------------------------------
      sequence seq_xchg_end;
         busy && XCHG_RSP[c].done;
      endsequence

      sequence seq_quiet_port;
         (!ch_start[c]) [*8];
      endsequence

      busy_window_a: assert property (ch_start[c] |=> busy ##0 !ch_start[c])
         else $error("Busy flag missing after start");
      busy_release_a: assert property (seq_xchg_end |=> !busy)
         else $error("Busy flag held after exchange end");
      port_gap_a: assert property (seq_xchg_end |=> seq_quiet_port)
         else $error("Exchange started inside port gap");
      fault_set_a: assert property (seq_xchg_end ##0 XCHG_RSP[c].fault
                                    |=> drv_fault_r[c] && drv_latch_r[c])
         else $error("Drive fault not recorded");
      latch_hold_a: assert property (drv_latch_r[c] && !run_rise
                                     |=> drv_latch_r[c])
         else $error("Fault latch dropped");
      step_hold_a: assert property (busy && !$rose(busy) |-> $stable(act_step_r[c]))
         else $error("Active step changed during exchange");
      run_clear_a: assert property (run_rise && !LINE_EVT[c].fault && !xdone
                                    |=> !ser_fault_r[c] && !drv_latch_r[c]
                                        && err_step_r[c] == 16'h0000)
         else $error("Faults not cleared on run entry");
      legacy_keep_a: assert property (legacy_r && xfault && !LINE_EVT[c].fault
                                      && !run_rise |=> $stable(ser_fault_r[c]))
         else $error("Legacy map raised serial fault");
      line_fault_a: assert property (LINE_EVT[c].fault |=> ser_fault_r[c]
                                     && ser_code_r[c] == $past(LINE_EVT[c].code))
         else $error("Line fault not recorded");
   end

   done_one_scan_a: assert property (SCAN_TICK && done_pend_r |=> done_flag_r)
      else $error("Completion flag not raised for the scan");
   done_drop_a: assert property (SCAN_TICK && !done_pend_r |=> !done_flag_r)
      else $error("Completion flag held beyond one scan");
   done_fault_a: assert property (|(ch_done & {XCHG_RSP[1].fault, XCHG_RSP[0].fault})
                                  |=> done_pend_r)
      else $error("Failed exchange not counted as complete");

endmodule

// File: drive_link_status_devices_tb.sv
// Self-checking bench of the drive link status bank.
// Assumes dls_pkg and dls_drive_model are compiled first.
`timescale 1ns/100ps
module drive_link_status_devices_tb;
   logic        CLK_SYS = 0, NRST = 0, S_AWVALID = 0, S_WVALID = 0, S_BREADY = 0;
   logic        S_ARVALID = 0, S_RREADY = 0, SCAN_TICK = 0, RUN_MODE = 1, fail = 0;
   logic [7:0]  S_AWADDR = 0, S_ARADDR = 0;
   logic [31:0] S_WDATA = 0;
   logic [3:0]  S_WSTRB = 4'hf;
   logic [2:0]  scan_cnt = 0;
   dls_pkg::dls_drv_req_t  [1:0] DRV_REQ = '0;
   dls_pkg::dls_line_evt_t [1:0] LINE_EVT = '0;
   dls_pkg::dls_xchg_rsp_t [1:0] XCHG_RSP;
   dls_pkg::dls_xchg_req_t [1:0] XCHG_REQ;
   wire         S_AWREADY, S_WREADY, S_BVALID, S_ARREADY, S_RVALID, INSTR_DONE;
   wire  [1:0]  S_BRESP, S_RRESP, DRIVE_BUSY;
   wire  [31:0] S_RDATA;
   int          n_errors = 0, cmp_count = 0;
   always #5 CLK_SYS = ~CLK_SYS;
   always @(posedge CLK_SYS) begin
      scan_cnt  <= scan_cnt + 3'h1;
      SCAN_TICK <= (scan_cnt == 3'h7);
   end
   dls_status_bank #(.GAP_CYCLES(20)) dut (.CLK_SYS(CLK_SYS), .NRST(NRST),
      .S_AWADDR(S_AWADDR), .S_AWVALID(S_AWVALID), .S_AWREADY(S_AWREADY), .S_WDATA(S_WDATA),
      .S_WSTRB(S_WSTRB), .S_WVALID(S_WVALID), .S_WREADY(S_WREADY), .S_BRESP(S_BRESP),
      .S_BVALID(S_BVALID), .S_BREADY(S_BREADY), .S_ARADDR(S_ARADDR), .S_ARVALID(S_ARVALID),
      .S_ARREADY(S_ARREADY), .S_RDATA(S_RDATA), .S_RRESP(S_RRESP), .S_RVALID(S_RVALID),
      .S_RREADY(S_RREADY), .SCAN_TICK(SCAN_TICK), .RUN_MODE(RUN_MODE), .DRV_REQ(DRV_REQ),
      .XCHG_RSP(XCHG_RSP), .LINE_EVT(LINE_EVT), .XCHG_REQ(XCHG_REQ),
      .DRIVE_BUSY(DRIVE_BUSY), .INSTR_DONE(INSTR_DONE));
   dls_drive_model drive (.clk(CLK_SYS), .nrst(NRST), .req(XCHG_REQ), .fail(fail),
      .rsp(XCHG_RSP));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int t;
      @(posedge CLK_SYS);
      S_AWADDR  <= a;
      S_WDATA   <= d;
      S_AWVALID <= 1'b1;
      S_WVALID  <= 1'b1;
      S_BREADY  <= 1'b1;
      for (t = 0; t < 50 && !S_BVALID; t++) begin
         @(posedge CLK_SYS);
         if (S_AWREADY) S_AWVALID <= 1'b0;
         if (S_WREADY) S_WVALID <= 1'b0;
      end
      S_BREADY <= 1'b0;
      chk({S_BVALID, S_BRESP}, {1'b1, r});
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      int t;
      @(posedge CLK_SYS);
      S_ARADDR  <= a;
      S_ARVALID <= 1'b1;
      S_RREADY  <= 1'b1;
      for (t = 0; t < 50 && !S_RVALID; t++) begin
         @(posedge CLK_SYS);
         if (S_ARREADY) S_ARVALID <= 1'b0;
      end
      S_RREADY <= 1'b0;
      chk(S_RDATA, e);
      chk({S_RVALID, S_RRESP}, {1'b1, r});
   endtask
   task automatic xfer(input int ch, input logic [2:0] cmd, input logic [15:0] st,
                       input logic f);
      int t;
      @(posedge CLK_SYS);
      DRV_REQ[ch] <= {1'b1, cmd, st};
      fail        <= f;
      for (t = 0; t < 80 && !DRIVE_BUSY[ch]; t++) @(posedge CLK_SYS);
      chk({DRIVE_BUSY[ch], XCHG_REQ[ch].cmd}, {1'b1, cmd});
      DRV_REQ[ch].cond <= 1'b0;
      axr(8'(ch * 32 + 8), {16'h0, st}, 2'b00);
      for (t = 0; t < 80 && DRIVE_BUSY[ch]; t++) @(posedge CLK_SYS);
      for (t = 0; t < 80 && !INSTR_DONE; t++) @(posedge CLK_SYS);
      for (t = 0; t < 80 && INSTR_DONE; t++) @(posedge CLK_SYS);
      chk(t, 8);
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      final_report();
   end
   task automatic test_regs();
      axr(8'h04, 32'h0, 2'b00);
      axw(8'h04, 32'h0000_000c, 2'b00);
      axr(8'h04, 32'h0000_000c, 2'b00);
      chk(32'(XCHG_REQ[0].wait_time), 32'h0000_000c);
      axw(8'h0c, 32'h0000_1234, 2'b00);
      axr(8'h0c, 32'h0, 2'b00);
      axr(8'h3c, 32'h0, 2'b10);
      $display("test registers done");
   endtask
   task automatic test_cmds();
      for (int c = 0; c < 5; c++) xfer(0, 3'(c), 16'h0100 + 16'(c), 1'b0);
      axr(8'h00, 32'h0, 2'b00);
      $display("test commands done");
   endtask
   task automatic test_fault();
      xfer(0, 3'h4, 16'h0222, 1'b1);
      axr(8'h00, 32'h0000_001d, 2'b00);
      axr(8'h0c, 32'h0000_0042, 2'b00);
      axr(8'h10, 32'h0000_0222, 2'b00);
      axr(8'h14, 32'h0000_0003, 2'b00);
      axr(8'h18, 32'h0000_0042, 2'b00);
      xfer(0, 3'h0, 16'h0223, 1'b0);
      axr(8'h00, 32'h0000_0019, 2'b00);
      $display("test drive fault done");
   endtask
   task automatic test_clear();
      RUN_MODE <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      RUN_MODE <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      axr(8'h00, 32'h0, 2'b00);
      for (int a = 3; a < 7; a++) axr(8'(a * 4), 32'h0, 2'b00);
      $display("test clear done");
   endtask
   task automatic test_line();
      LINE_EVT[1] <= {1'b1, 16'h0abc};
      @(posedge CLK_SYS);
      LINE_EVT[1] <= '0;
      axr(8'h20, 32'h0000_0001, 2'b00);
      axr(8'h38, 32'h0000_0abc, 2'b00);
      axr(8'h00, 32'h0, 2'b00);
      xfer(1, 3'h2, 16'h0333, 1'b0);
      axr(8'h20, 32'h0000_0001, 2'b00);
      $display("test line fault done");
   endtask
   task automatic test_legacy();
      axw(8'h44, 32'h0000_0001, 2'b00);
      xfer(0, 3'h1, 16'h0444, 1'b1);
      axr(8'h00, 32'h0000_000c, 2'b00);
      axr(8'h44, 32'h0000_0001, 2'b00);
      axw(8'h48, 32'h0000_0001, 2'b10);
      $display("test legacy map done");
   endtask
   initial begin
      repeat (20) @(posedge CLK_SYS);
      NRST <= 1'b1;
      @(posedge CLK_SYS);
      test_regs();
      test_cmds();
      test_fault();
      test_clear();
      test_line();
      test_legacy();
      final_report();
   end
endmodule
